// [common/crossbar_pkg.sv]
/*
  Shared constants for the crossbar route-select block: register decode,
  field positions, reset values and the peripheral function list.
  Assumes one system clock domain and an 8-bit special-function bus.
*/
package crossbar_pkg;
  localparam int DATA_W = 8;
  localparam int NUM_PINS = 16;
  localparam int PIN_W = 4;
  localparam int NUM_FN = 24;
  localparam int CNT_W = 3;

  localparam logic [7:0] SFR_PAGE_CFG = 8'h0F;
  localparam logic [7:0] ADDR_ROUTE0 = 8'hE1;
  localparam logic [7:0] ADDR_ROUTE1 = 8'hE2;
  localparam logic [7:0] ROUTE0_RESET = 8'h00;
  localparam logic [7:0] ROUTE1_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // First route-select register bits.
  localparam int B_CMP1_ASYNC = 7;
  localparam int B_CMP1_SYNC = 6;
  localparam int B_CMP0_ASYNC = 5;
  localparam int B_CMP0_SYNC = 4;
  localparam int B_TWOWIRE = 3;
  localparam int B_SERIAL_PERIPH = 2;
  localparam int B_CANBUS = 1;
  localparam int B_ASYNC_SERIAL = 0;

  // Second route-select register bits.
  localparam int B_TIMER1_IN = 7;
  localparam int B_TIMER0_IN = 6;
  localparam int B_COUNTER_IN = 5;
  localparam int B_CAPCOMP_HI = 4;
  localparam int B_CAPCOMP_LO = 2;
  localparam int B_SYSCLOCK_OUT = 1;
  localparam logic [CNT_W-1:0] CAPCOMP_MAX = 3'b110;

  // Fixed pins of the async serial port and the controller area network.
  localparam logic [PIN_W-1:0] PIN_SER_TX = 4'h4;
  localparam logic [PIN_W-1:0] PIN_SER_RX = 4'h5;
  localparam logic [PIN_W-1:0] PIN_CAN_TX = 4'h6;
  localparam logic [PIN_W-1:0] PIN_CAN_RX = 4'h7;

  // Function indices, listed in falling crossbar priority.
  localparam int F_SER_TX = 0;
  localparam int F_SER_RX = 1;
  localparam int F_CAN_TX = 2;
  localparam int F_CAN_RX = 3;
  localparam int F_SPI_SCK = 4;
  localparam int F_SPI_MISO = 5;
  localparam int F_SPI_MOSI = 6;
  localparam int F_SPI_NSS = 7;
  localparam int F_TW_DATA = 8;
  localparam int F_TW_CLK = 9;
  localparam int F_CMP0_SYNC = 10;
  localparam int F_CMP0_ASYNC = 11;
  localparam int F_CMP1_SYNC = 12;
  localparam int F_CMP1_ASYNC = 13;
  localparam int F_SYSTEM_CLOCK_SIGNAL = 14;
  localparam int F_CAPCOMP0 = 15;
  localparam int F_COUNTER_IN = 21;
  localparam int F_TIMER0_IN = 22;
  localparam int F_TIMER1_IN = 23;
  localparam int NUM_FIXED = 4;

  localparam logic FN_IN_IDLE = 1'b1;
endpackage

// [common/pin_assign_if.sv]
/*
  Carrier between the crossbar top and its pin assignment engine.
  Assumes both ends sit on the same clock; all signals are combinational.
*/
interface pin_assign_if;
  import crossbar_pkg::*;
  logic [NUM_FN-1:0] fn_req;
  logic [NUM_PINS-1:0] pin_skip;
  logic [NUM_FN-1:0][PIN_W-1:0] fn_pin;
  logic [NUM_FN-1:0] fn_hit;

  modport engine (input fn_req, input pin_skip, output fn_pin, output fn_hit);
  modport user (output fn_req, output pin_skip, input fn_pin, input fn_hit);
endinterface

// [hdl/crossbar_route.sv]
/*
  Crossbar route-select registers and the pin multiplexer they steer.
  Holds both route-select registers on the special-function bus, builds
  the function request list, asks the assignment engine for pins and
  drives the port pins, returning pin levels to the peripherals.
  Assumes the peripheral side drives fn_out/fn_oe on clk_sys and that the
  pin inputs are asynchronous to it.
*/
// Overview of operation
// - Register 0 bit 7 routes comparator 1 asynchronous output to a pin.
// - Register 0 bit 6 routes comparator 1 synchronous output to a pin.
// - Register 0 bit 5 routes comparator 0 asynchronous output to a pin.
// - Register 0 bit 4 routes comparator 0 synchronous output to a pin.
// - Register 0 bit 3 routes both two-wire bus signals to pins.
// - Register 0 bit 2 routes serial peripheral signals, three or four pins.
// - Register 0 bit 1 puts CAN transmit on P0.6, receive on P0.7.
// - Register 0 bit 0 puts serial transmit on P0.4, receive on P0.5.
// - Register 0 at 0xE1 page 0x0F, fully read/write, resets to zero.
// - Register 1 bit 7 connects the timer 1 external input to a pin.
// - Register 1 bit 6 connects the timer 0 external input to a pin.
// - Register 1 bit 5 connects the counter external input to a pin.
// - Register 1 bits 4:2 route the first N capture pins; 111 reserved.
// - Register 1 bit 1 drives the system clock out on a pin.
// - Register 1 at 0xE2 page 0x0F, every bit resets to zero.
// - Other enabled functions take the lowest unassigned pin in priority order.
// - Skipped pins are passed over as if already taken, except by the fixed serial and CAN pins.
// - With the global enable clear, pins stay inputs, selections ignored.
module crossbar_route
  import crossbar_pkg::*;
(
  input wire logic clk_sys, // System clock, 200 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [7:0] sfr_addr, // Special-function address
  input wire logic [7:0] sfr_page, // Special-function page
  input wire logic sfr_wr, // Write strobe, one cycle
  input wire logic sfr_rd, // Read strobe, one cycle
  input wire logic [DATA_W-1:0] sfr_wdata, // Write data
  output logic [DATA_W-1:0] sfr_rdata, // Read data, registered
  output logic sfr_rd_hit, // Read matched one of our registers
  input wire logic crossbar_global_enable, // Crossbar enable level
  input wire logic [NUM_PINS-1:0] pin_skip_mask, // Pins the crossbar passes over
  input wire logic spi_four_wire, // Serial peripheral uses its select pin
  input wire logic [NUM_FN-1:0] fn_out, // Peripheral output levels
  input wire logic [NUM_FN-1:0] fn_oe, // Peripheral output enables
  output logic [NUM_FN-1:0] fn_in, // Pin levels returned to peripherals
  output logic [NUM_FN-1:0] fn_routed, // Function currently owns a pin
  input wire logic [NUM_PINS-1:0] gpio_out, // Plain port output levels
  input wire logic [NUM_PINS-1:0] gpio_oe, // Plain port output enables
  output logic [NUM_PINS-1:0] port_level, // Synchronised pin levels
  input wire logic [NUM_PINS-1:0] pin_i, // Pad input levels
  output logic [NUM_PINS-1:0] pin_o, // Pad output levels
  output logic [NUM_PINS-1:0] pin_oe // Pad output enables, high drives
);
  logic [DATA_W-1:0] route0_q;
  logic [DATA_W-1:0] route1_q;
  logic [DATA_W-1:0] rdata_d;
  logic rd_hit_d;
  logic sel_route0;
  logic sel_route1;

  logic cmp1_async_route_en;
  logic cmp1_sync_route_en;
  logic cmp0_async_route_en;
  logic cmp0_sync_route_en;
  logic twowire_route_en;
  logic serial_periph_route_en;
  logic canbus_route_en;
  logic async_serial_route_en;
  logic timer1_input_route_en;
  logic timer0_input_route_en;
  logic counter_ext_input_route_en;
  logic [CNT_W-1:0] capcomp_module_count;
  logic sysclock_out_route_en;

  logic [NUM_FN-1:0] req;
  logic [NUM_PINS-1:0] pin_meta_q;
  logic [NUM_PINS-1:0] pin_sync_q;
  logic [NUM_PINS-1:0] pin_o_d;
  logic [NUM_PINS-1:0] pin_oe_d;
  logic [NUM_FN-1:0] fn_in_d;
  logic [NUM_FN-1:0] routed_d;

  pin_assign_if pa ();

  // Register decode. Both registers live on the configuration page only.
  always_comb begin
    sel_route0 = 1'b0;
    sel_route1 = 1'b0;
    if (sfr_page == SFR_PAGE_CFG && sfr_addr == ADDR_ROUTE0) begin
      sel_route0 = 1'b1;
    end else if (sfr_page == SFR_PAGE_CFG && sfr_addr == ADDR_ROUTE1) begin
      sel_route1 = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      route0_q <= ROUTE0_RESET;
    end else if (sfr_wr && sel_route0) begin
      route0_q <= sfr_wdata;
    end
  end

  // The reserved low bit is stored as written so software reads back its
  // own value; it reaches no routing logic.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      route1_q <= ROUTE1_RESET;
    end else if (sfr_wr && sel_route1) begin
      route1_q <= sfr_wdata;
    end
  end

  always_comb begin
    rdata_d = READ_IDLE;
    rd_hit_d = 1'b0;
    if (sfr_rd && sel_route0) begin
      rdata_d = route0_q;
      rd_hit_d = 1'b1;
    end else if (sfr_rd && sel_route1) begin
      rdata_d = route1_q;
      rd_hit_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sfr_rdata <= READ_IDLE;
      sfr_rd_hit <= 1'b0;
    end else begin
      sfr_rdata <= rdata_d;
      sfr_rd_hit <= rd_hit_d;
    end
  end

  // Field extraction.
  assign cmp1_async_route_en = route0_q[B_CMP1_ASYNC];
  assign cmp1_sync_route_en = route0_q[B_CMP1_SYNC];
  assign cmp0_async_route_en = route0_q[B_CMP0_ASYNC];
  assign cmp0_sync_route_en = route0_q[B_CMP0_SYNC];
  assign twowire_route_en = route0_q[B_TWOWIRE];
  assign serial_periph_route_en = route0_q[B_SERIAL_PERIPH];
  assign canbus_route_en = route0_q[B_CANBUS];
  assign async_serial_route_en = route0_q[B_ASYNC_SERIAL];
  assign timer1_input_route_en = route1_q[B_TIMER1_IN];
  assign timer0_input_route_en = route1_q[B_TIMER0_IN];
  assign counter_ext_input_route_en = route1_q[B_COUNTER_IN];
  assign capcomp_module_count = route1_q[B_CAPCOMP_HI:B_CAPCOMP_LO];
  assign sysclock_out_route_en = route1_q[B_SYSCLOCK_OUT];

  // Request list. Every request is gated by the global enable, so with it
  // clear nothing is routed whatever the registers hold.
  always_comb begin
    req = '0;
    req[F_SER_TX] = async_serial_route_en;
    req[F_SER_RX] = async_serial_route_en;
    req[F_CAN_TX] = canbus_route_en;
    req[F_CAN_RX] = canbus_route_en;
    req[F_SPI_SCK] = serial_periph_route_en;
    req[F_SPI_MISO] = serial_periph_route_en;
    req[F_SPI_MOSI] = serial_periph_route_en;
    req[F_SPI_NSS] = serial_periph_route_en && spi_four_wire;
    req[F_TW_DATA] = twowire_route_en;
    req[F_TW_CLK] = twowire_route_en;
    req[F_CMP0_SYNC] = cmp0_sync_route_en;
    req[F_CMP0_ASYNC] = cmp0_async_route_en;
    req[F_CMP1_SYNC] = cmp1_sync_route_en;
    req[F_CMP1_ASYNC] = cmp1_async_route_en;
    req[F_SYSTEM_CLOCK_SIGNAL] = sysclock_out_route_en;
    req[F_COUNTER_IN] = counter_ext_input_route_en;
    req[F_TIMER0_IN] = timer0_input_route_en;
    req[F_TIMER1_IN] = timer1_input_route_en;
    // The reserved count 111 routes nothing rather than guessing a width.
    for (int m = 0; m < F_COUNTER_IN - F_CAPCOMP0; m++) begin
      req[F_CAPCOMP0 + m] = (capcomp_module_count <= CAPCOMP_MAX) &&
                            (CNT_W'(m) < capcomp_module_count);
    end
    if (!crossbar_global_enable) begin
      req = '0;
    end
  end

  assign pa.fn_req = req;
  assign pa.pin_skip = pin_skip_mask;

  pin_assign_engine u_engine (
    .pa (pa)
  );

  // Pad inputs are asynchronous; two stages before any use.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= pin_i;
      pin_sync_q <= pin_meta_q;
    end
  end

  assign port_level = pin_sync_q;

  // Per-pin output multiplexer. A pin owned by no function falls back to
  // plain port output; with the crossbar disabled every driver is off.
  generate
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
      always_comb begin
        pin_o_d[p] = gpio_out[p];
        pin_oe_d[p] = gpio_oe[p];
        for (int f = 0; f < NUM_FN; f++) begin
          if (pa.fn_hit[f] && pa.fn_pin[f] == PIN_W'(p)) begin
            if (f == F_TW_DATA || f == F_TW_CLK) begin
              // Two-wire pins are open drain: pull low only, never drive high.
              pin_o_d[p] = 1'b0;
              pin_oe_d[p] = fn_oe[f] && !fn_out[f];
            end else begin
              pin_o_d[p] = fn_out[f];
              pin_oe_d[p] = fn_oe[f];
            end
          end
        end
        if (!crossbar_global_enable) begin
          pin_o_d[p] = 1'b0;
          pin_oe_d[p] = 1'b0;
        end
      end
    end
  endgenerate

  // Inputs back to peripherals: an unrouted function sees the idle level,
  // so a disabled receiver never picks up a stray edge from a pin.
  generate
    for (genvar f = 0; f < NUM_FN; f++) begin : g_fn
      always_comb begin
        routed_d[f] = pa.fn_hit[f];
        fn_in_d[f] = pa.fn_hit[f] ? pin_sync_q[pa.fn_pin[f]] : FN_IN_IDLE;
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_o <= '0;
      pin_oe <= '0;
    end else begin
      pin_o <= pin_o_d;
      pin_oe <= pin_oe_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fn_in <= {NUM_FN{FN_IN_IDLE}};
      fn_routed <= '0;
    end else begin
      fn_in <= fn_in_d;
      fn_routed <= routed_d;
    end
  end
endmodule

// [hdl/pin_assign_engine.sv]
/*
  Priority pin assignment: fixed-pin functions first, then every other
  requested function takes the lowest free, unskipped pin in index order.
  Assumes requests and skip mask are stable, same-clock levels.
*/
module pin_assign_engine
  import crossbar_pkg::*;
(
  pin_assign_if.engine pa // Requests in, pin choices out
);
  logic [NUM_PINS-1:0] taken;
  logic [NUM_FN-1:0][PIN_W-1:0] pin_d;
  logic [NUM_FN-1:0] hit_d;
  logic found;

  always_comb begin
    taken = pa.pin_skip;
    pin_d = '0;
    hit_d = '0;
    found = 1'b0;
    // The fixed functions ignore the skip mask and claim their pins first.
    if (pa.fn_req[F_SER_TX]) begin
      pin_d[F_SER_TX] = PIN_SER_TX;
      pin_d[F_SER_RX] = PIN_SER_RX;
      hit_d[F_SER_TX] = 1'b1;
      hit_d[F_SER_RX] = 1'b1;
      taken[PIN_SER_TX] = 1'b1;
      taken[PIN_SER_RX] = 1'b1;
    end
    if (pa.fn_req[F_CAN_TX]) begin
      pin_d[F_CAN_TX] = PIN_CAN_TX;
      pin_d[F_CAN_RX] = PIN_CAN_RX;
      hit_d[F_CAN_TX] = 1'b1;
      hit_d[F_CAN_RX] = 1'b1;
      taken[PIN_CAN_TX] = 1'b1;
      taken[PIN_CAN_RX] = 1'b1;
    end
    for (int f = NUM_FIXED; f < NUM_FN; f++) begin
      found = 1'b0;
      if (pa.fn_req[f]) begin
        for (int p = 0; p < NUM_PINS; p++) begin
          if (!found && !taken[p]) begin
            found = 1'b1;
            taken[p] = 1'b1;
            pin_d[f] = PIN_W'(p);
            hit_d[f] = 1'b1;
          end
        end
      end
    end
  end

  // A request that finds no free pin simply stays unrouted.
  assign pa.fn_pin = pin_d;
  assign pa.fn_hit = hit_d;
endmodule

// [verif/crossbar_route_assertions.sv]
/*
  Port checker for the crossbar route block.
  Assumes one clock; register contents are shadowed from bus writes.
*/
module crossbar_route_assertions
  import crossbar_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic [7:0] sfr_addr, // Address
  input wire logic [7:0] sfr_page, // Page
  input wire logic sfr_wr, // Write strobe
  input wire logic sfr_rd, // Read strobe
  input wire logic [DATA_W-1:0] sfr_wdata, // Write data
  input wire logic [DATA_W-1:0] sfr_rdata, // Read data
  input wire logic sfr_rd_hit, // Read hit
  input wire logic crossbar_global_enable, // Enable
  input wire logic spi_four_wire, // Select pin used
  input wire logic [NUM_FN-1:0] fn_oe, // Function enables
  input wire logic [NUM_FN-1:0] fn_routed, // Function owns pin
  input wire logic [NUM_PINS-1:0] pin_oe // Pad enables
);
  logic [7:0] sh0_q;
  logic [7:0] sh1_q;
  logic [NUM_FN-1:0] allow;
  logic pg;
  assign pg = sfr_page == SFR_PAGE_CFG;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sh0_q <= ROUTE0_RESET;
      sh1_q <= ROUTE1_RESET;
    end else if (sfr_wr && pg) begin
      if (sfr_addr == ADDR_ROUTE0) sh0_q <= sfr_wdata;
      if (sfr_addr == ADDR_ROUTE1) sh1_q <= sfr_wdata;
    end
  end
  // Functions a routed flag may legally show; anything outside is a leak.
  always_comb begin
    allow = '0;
    allow[1:0] = {2{sh0_q[B_ASYNC_SERIAL]}};
    allow[3:2] = {2{sh0_q[B_CANBUS]}};
    allow[6:4] = {3{sh0_q[B_SERIAL_PERIPH]}};
    allow[7] = sh0_q[B_SERIAL_PERIPH] & spi_four_wire;
    allow[9:8] = {2{sh0_q[B_TWOWIRE]}};
    allow[13:10] = sh0_q[7:4];
    allow[14] = sh1_q[B_SYSCLOCK_OUT];
    for (int k = 0; k < 6; k++) begin
      allow[F_CAPCOMP0+k] = (sh1_q[4:2] != 3'h7) && (k < int'(sh1_q[4:2]));
    end
    allow[23:21] = sh1_q[7:5];
    if (!crossbar_global_enable) allow = '0;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_read_reg0: assert property (
    sfr_rd && pg && sfr_addr == ADDR_ROUTE0 |=> sfr_rd_hit && sfr_rdata == $past(sh0_q))
    else $error("register 0 read wrong");
  a_read_reg1: assert property (
    sfr_rd && pg && sfr_addr == ADDR_ROUTE1 |=> sfr_rd_hit && sfr_rdata == $past(sh1_q))
    else $error("register 1 read wrong");
  a_read_refused: assert property (
    sfr_rd && !(pg && (sfr_addr == ADDR_ROUTE0 || sfr_addr == ADDR_ROUTE1))
    |=> !sfr_rd_hit && sfr_rdata == READ_IDLE)
    else $error("foreign read answered");
  a_read_idle: assert property (
    !sfr_rd |=> sfr_rdata == READ_IDLE && !sfr_rd_hit)
    else $error("read data without read");
  a_disabled_float: assert property (
    !crossbar_global_enable |=> pin_oe == '0 && fn_routed == '0)
    else $error("pads driven while disabled");
  a_route_gated: assert property (
    (fn_routed & ~$past(allow)) == '0)
    else $error("unselected function routed");
  a_can_fixed: assert property (
    $past(rst_n) && $past(allow[F_CAN_TX]) |->
    fn_routed[F_CAN_RX:F_CAN_TX] == 2'b11 && pin_oe[PIN_CAN_TX] == $past(fn_oe[F_CAN_TX]))
    else $error("network pins not fixed");
  a_serial_fixed: assert property (
    $past(rst_n) && $past(allow[F_SER_TX]) |->
    fn_routed[F_SER_RX:F_SER_TX] == 2'b11 && pin_oe[PIN_SER_TX] == $past(fn_oe[F_SER_TX]))
    else $error("serial pins not fixed");
endmodule

bind crossbar_route crossbar_route_assertions u_chk (.clk_sys, .rst_n, .sfr_addr,
  .sfr_page, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_rd_hit,
  .crossbar_global_enable, .spi_four_wire, .fn_oe, .fn_routed, .pin_oe);

// [verif/crossbar_route_tb_top.sv]
/*
  Testbench for the crossbar route block with a pad model on its pins.
  Assumes inputs change on falling edges and routing settles in four cycles.
*/
module crossbar_route_tb_top
  import crossbar_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst_n, sfr_wr, sfr_rd, sfr_rd_hit, crossbar_global_enable, spi_four_wire;
  logic [7:0] sfr_addr, sfr_page, sfr_wdata, sfr_rdata;
  logic [NUM_FN-1:0] fn_out, fn_oe, fn_in, fn_routed;
  logic [NUM_PINS-1:0] pin_skip_mask, gpio_out, gpio_oe, port_level, pin_i, pin_o, pin_oe;
  logic [NUM_PINS-1:0] ext_en, ext_val;
  int bad_count, n_checks;
  crossbar_route DUT (.clk_sys, .rst_n, .sfr_addr, .sfr_page, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_rdata, .sfr_rd_hit, .crossbar_global_enable, .pin_skip_mask, .spi_four_wire,
    .fn_out, .fn_oe, .fn_in, .fn_routed, .gpio_out, .gpio_oe, .port_level, .pin_i, .pin_o,
    .pin_oe);
  pad_model pads (.pin_o, .pin_oe, .ext_en, .ext_val, .pin_i);
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] page, input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_sys);
    sfr_page = page;
    sfr_addr = addr;
    sfr_wdata = data;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] page, input logic [7:0] addr, input logic [7:0] exp);
    @(negedge clk_sys);
    sfr_page = page;
    sfr_addr = addr;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    chk({16'h0000, sfr_rdata}, {16'h0000, exp});
    chk({23'h000000, sfr_rd_hit},
      {23'h000000, page == SFR_PAGE_CFG && (addr == ADDR_ROUTE0 || addr == ADDR_ROUTE1)});
  endtask
  task automatic setup(input logic [7:0] r0, input logic [7:0] r1, input logic [15:0] skip);
    pin_skip_mask = skip;
    wr(SFR_PAGE_CFG, ADDR_ROUTE0, r0);
    wr(SFR_PAGE_CFG, ADDR_ROUTE1, r1);
    repeat (5) @(negedge clk_sys);
  endtask
  task automatic t_registers();
    rd_chk(SFR_PAGE_CFG, ADDR_ROUTE0, ROUTE0_RESET);
    rd_chk(SFR_PAGE_CFG, ADDR_ROUTE1, ROUTE1_RESET);
    wr(SFR_PAGE_CFG, ADDR_ROUTE0, 8'hA5);
    wr(SFR_PAGE_CFG, ADDR_ROUTE1, 8'h5A);
    wr(8'h00, ADDR_ROUTE0, 8'hFF);
    rd_chk(SFR_PAGE_CFG, ADDR_ROUTE0, 8'hA5);
    rd_chk(SFR_PAGE_CFG, ADDR_ROUTE1, 8'h5A);
    rd_chk(SFR_PAGE_CFG, 8'hE3, READ_IDLE);
    rd_chk(8'h00, ADDR_ROUTE1, READ_IDLE);
  endtask
  task automatic t_twowire();
    fn_oe[F_TW_DATA] = 1'b1;
    ext_en[1] = 1'b1;
    setup(8'h08, 8'h00, 16'h0000);
    chk(fn_routed, 24'h000300);
    chk({8'h00, pin_oe}, 24'h000001);
    chk(fn_in, 24'hFFFCFF);
    ext_en[1] = 1'b0;
    setup(8'h08, 8'h00, 16'h0003);
    chk({8'h00, pin_oe}, 24'h000004);
    chk(fn_in, 24'hFFFEFF);
  endtask
  task automatic t_fixed();
    fn_oe = 24'h000005;
    fn_out = 24'h000001;
    gpio_oe = 16'h0121;
    gpio_out = 16'h0021;
    setup(8'h03, 8'h00, 16'h00F0);
    chk(fn_routed, 24'h00000F);
    chk({8'h00, pin_oe}, 24'h000151);
    chk({8'h00, pin_o}, 24'h000011);
    chk({8'h00, port_level}, 24'h00FEBF);
    chk(fn_in, 24'hFFFFFB);
  endtask
  task automatic t_singles();
    for (int i = 0; i < 4; i++) begin
      setup(8'h80 >> i, 8'h00, 16'h0000);
      chk(fn_routed, 24'h002000 >> i);
    end
    for (int i = 0; i < 3; i++) begin
      setup(8'h00, 8'h80 >> i, 16'h0000);
      chk(fn_routed, 24'h800000 >> i);
    end
    setup(8'h00, 8'h02, 16'h0000);
    chk(fn_routed, 24'h004000);
    setup(8'h04, 8'h00, 16'h0000);
    chk(fn_routed, 24'h000070);
    spi_four_wire = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(fn_routed, 24'h0000F0);
  endtask
  task automatic t_capcomp();
    logic [23:0] exp;
    for (int n = 0; n < 8; n++) begin
      setup(8'h00, 8'(n << 2), 16'h0000);
      exp = (n == 7) ? 24'h000000 : 24'((2 ** n - 1) << F_CAPCOMP0);
      chk(fn_routed, exp);
    end
  endtask
  task automatic t_disable();
    setup(8'hFF, 8'hFE, 16'h0000);
    crossbar_global_enable = 1'b0;
    gpio_oe = 16'hFFFF;
    fn_oe = 24'hFFFFFF;
    repeat (5) @(negedge clk_sys);
    chk(fn_routed, 24'h000000);
    chk({8'h00, pin_oe}, 24'h000000);
    chk(fn_in, 24'hFFFFFF);
    rd_chk(SFR_PAGE_CFG, ADDR_ROUTE0, 8'hFF);
    rd_chk(SFR_PAGE_CFG, ADDR_ROUTE1, 8'hFE);
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    {rst_n, sfr_wr, sfr_rd, crossbar_global_enable, spi_four_wire} = 5'h00;
    {sfr_addr, sfr_page, sfr_wdata} = 24'h000000;
    {fn_out, fn_oe} = '0;
    {pin_skip_mask, gpio_out, gpio_oe, ext_en, ext_val} = '0;
    bad_count = 0;
    n_checks = 0;
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    t_registers();
    crossbar_global_enable = 1'b1;
    t_twowire();
    t_fixed();
    t_singles();
    t_capcomp();
    t_disable();
    conclude();
  end
endmodule

// [verif/pad_model.sv]
/*
  Pads and outside world: device drive, else an external driver, else pull-up.
  Assumes the bench owns the external drivers.
*/
module pad_model
  import crossbar_pkg::*;
(
  input wire logic [NUM_PINS-1:0] pin_o, // Device levels
  input wire logic [NUM_PINS-1:0] pin_oe, // Device enables
  input wire logic [NUM_PINS-1:0] ext_en, // External enables
  input wire logic [NUM_PINS-1:0] ext_val, // External levels
  output logic [NUM_PINS-1:0] pin_i // Resolved levels
);
  timeunit 1ns;
  timeprecision 1ps;
  // A released pad takes the external level if one drives it, else the pull-up level, never the stale driven value.
  always_comb begin
    for (int p = 0; p < NUM_PINS; p++) begin
      pin_i[p] = pin_oe[p] ? pin_o[p] : (ext_en[p] ? ext_val[p] : 1'b1);
    end
  end
endmodule
